// *** inc/pwr_pkg.sv ***
// Package for the power-down mode controller: register map, fields, states, counts.
// Assumes a 125 MHz system clock and an APB register port with 32-bit data.
package pwr_pkg;
    localparam logic [7:0] SYSCTRL_OFFSET    = 8'h00;
    localparam logic [7:0] CLKDIV_OFFSET     = 8'h04;
    localparam logic [7:0] STATUS_OFFSET     = 8'h08;
    localparam logic [7:0] MODSTBY_OFFSET    = 8'h0c;
    localparam int         HW_STANDBY_PIN_SEL_BIT      = 7;
    localparam int         SETTLE_LSB        = 4;
    localparam logic [2:0] SETTLE_RESET      = 3'h0;
    localparam logic       HW_STANDBY_PIN_SEL_RESET    = 1'b0;
    localparam logic [1:0] CLKDIV_RESET      = 2'h0;
    localparam logic [7:0] MODSTBY_RESET     = 8'h00;
    localparam logic [2:0] SETTLE_ILLEGAL    = 3'h7;
    localparam int         SETTLE_CNT_WIDTH  = 22;
    localparam int         SYNC_STAGES       = 3;
    typedef enum logic [2:0] {RUN, SLEEP, SWSTBY, SETTLE, RESET_HOLD, HWSTBY} mode_type;

    // Settling wait in states for each settle-time code
    function automatic logic [SETTLE_CNT_WIDTH-1:0] settle_states(input logic [2:0] code);
        case (code)
            3'h0:    settle_states = 22'd8192;
            3'h1:    settle_states = 22'd16384;
            3'h2:    settle_states = 22'd32768;
            3'h3:    settle_states = 22'd65536;
            3'h4:    settle_states = 22'd131072;
            3'h5:    settle_states = 22'd262144;
            3'h6:    settle_states = 22'd1024;
            default: settle_states = 22'd1024;
        endcase
    endfunction
endpackage

// *** design/pin_sync.sv ***
// Three-flop synchroniser with agreement filter for one asynchronous pin.
// Assumes clk is the system clock and rst a synchronous reset.
`timescale 1ns/100ps
module pin_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Pin and filtered level
    input  wire logic pinIn,
    output logic      level
);
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic       next_level;

    always_comb begin
        next_stage = {stage[1:0], pinIn};
        next_level = (stage[1] == stage[2]) ? stage[2] : level;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stage <= {3{RESET_LEVEL}};
            level <= RESET_LEVEL;
        end else begin
            stage <= next_stage;
            level <= next_level;
        end
    end
endmodule

// *** design/divide_tick.sv ***
// Divided-state tick generator: one-cycle enable every 1, 2, 4 or 8 cycles.
// Assumes it is cleared whenever the settling count starts.
`timescale 1ns/100ps
module divide_tick (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Control
    input  wire logic       clear,
    input  wire logic [1:0] divide,
    // Tick
    output logic            tick
);
    logic [2:0] count;
    logic [2:0] next_count;
    logic [2:0] limit;

    always_comb begin
        limit      = 3'((4'h1 << divide) - 4'h1);
        next_count = (clear || count >= limit) ? 3'h0 : 3'(count + 3'h1);
    end

    assign tick = !clear && (count >= limit);

    always_ff @(posedge clk) begin
        if (rst) begin
            count <= 3'h0;
        end else begin
            count <= next_count;
        end
    end
endmodule

// *** design/power_down_mode_control.sv ***
// Power-down mode controller: sleep, software standby, wake and settling wait.
// Assumes an APB master, a CPU that pulses sleepExec, and raw pins from outside.
`timescale 1ns/100ps
// Behaviour
// - Sleep instruction with standby select 0 enters sleep mode
// - CPU halts on sleep entry, its registers kept
// - DMA, DRAM, peripherals keep running in sleep except module-standby ones
// - Accepted interrupt ends sleep and starts interrupt handling
// - Interrupt disabled inside its peripheral does not wake sleep
// - Masked non-NMI interrupt does not end sleep
// - Reset pin low during sleep enters reset state
// - Hardware standby pin low during sleep enters hardware standby
// - Sleep with standby select 1 enters software standby, stopping clock
// - Software standby resets DMA and peripherals, keeps CPU, RAM, ports
// - Refresh counter and refresh status bits 7,6 cleared in standby
// - NMI or enabled IRQ0-2 restarts oscillator, settles, then interrupt
// - Disabled or CPU-masked IRQ0-2 does not end software standby
// - Reset pin low in standby restarts clocks at once; reset handling after
// - Hardware standby pin low in software standby enters hardware standby
// - Settle code selects 8192..262144 or 1024 states; 111 illegal
// - Standby select resets to 0
module power_down_mode_control (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // CPU side
    input  wire logic        sleepExec,
    input  wire logic        intAccepted,
    input  wire logic        nmiReq,
    input  wire logic [2:0]  irqReq,
    input  wire logic [2:0]  irqEnable,
    input  wire logic        cpuIrqMasked,
    // Pins
    input  wire logic        external_reset_pin_n,
    input  wire logic        hw_standby_pin_n,
    // Control outputs
    output logic             cpuHalt,
    output logic             clockStop,
    output logic             periphReset,
    output logic [7:0]       moduleHalt,
    output logic             refreshInit,
    output logic             intExcStart,
    output logic             resetExcStart,
    output logic             chipReset,
    output logic             hwStandby
);
    import pwr_pkg::*;

    logic                        standby_select;
    logic [2:0]                  settle_time_select;
    logic [1:0]                  clockDivide;
    logic [7:0]                  moduleStandby;
    logic                        next_standby_select;
    logic [2:0]                  next_settle_time_select;
    logic [1:0]                  next_clockDivide;
    logic [7:0]                  next_moduleStandby;
    logic                        resetLevel;
    logic                        stbyLevel;
    logic                        divTick;
    logic                        wakeIrq;
    logic                        wrStrobe;
    mode_type                    mode;
    mode_type                    next_mode;
    logic [SETTLE_CNT_WIDTH-1:0] settleCnt;
    logic [SETTLE_CNT_WIDTH-1:0] next_settleCnt;
    logic                        next_intExcStart;
    logic                        next_resetExcStart;
    logic [31:0]                 next_prdata;
    logic [SETTLE_CNT_WIDTH+2:0] settleCycles;
    logic [SETTLE_CNT_WIDTH+2:0] next_settleCycles;

    pin_sync #(.RESET_LEVEL(1'b1)) resetSync (
        .clk   (clk),
        .rst   (rst),
        .pinIn (external_reset_pin_n),
        .level (resetLevel)
    );

    pin_sync #(.RESET_LEVEL(1'b1)) stbySync (
        .clk   (clk),
        .rst   (rst),
        .pinIn (hw_standby_pin_n),
        .level (stbyLevel)
    );

    divide_tick settleTick (
        .clk    (clk),
        .rst    (rst),
        .clear  (mode != SETTLE),
        .divide (clockDivide),
        .tick   (divTick)
    );

    // APB: zero wait states, unmapped addresses error
    assign pready   = 1'b1;
    assign wrStrobe = psel && penable && pwrite;
    assign pslverr  = psel && penable && !(paddr == SYSCTRL_OFFSET || paddr == CLKDIV_OFFSET
                      || paddr == STATUS_OFFSET || paddr == MODSTBY_OFFSET);

    always_comb begin
        next_standby_select     = standby_select;
        next_settle_time_select = settle_time_select;
        next_clockDivide        = clockDivide;
        next_moduleStandby      = moduleStandby;
        if (wrStrobe && paddr == SYSCTRL_OFFSET) begin
            next_standby_select     = pwdata[HW_STANDBY_PIN_SEL_BIT];
            next_settle_time_select = pwdata[SETTLE_LSB+2:SETTLE_LSB];
        end
        if (wrStrobe && paddr == CLKDIV_OFFSET) begin
            next_clockDivide = pwdata[1:0];
        end
        if (wrStrobe && paddr == MODSTBY_OFFSET) begin
            next_moduleStandby = pwdata[7:0];
        end
        next_prdata = 32'h0;
        case (paddr)
            SYSCTRL_OFFSET: next_prdata = {24'h0, standby_select, settle_time_select, 4'h0};
            CLKDIV_OFFSET:  next_prdata = {30'h0, clockDivide};
            STATUS_OFFSET:  next_prdata = {29'h0, mode};
            MODSTBY_OFFSET: next_prdata = {24'h0, moduleStandby};
            default:        next_prdata = 32'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            standby_select     <= HW_STANDBY_PIN_SEL_RESET;
            settle_time_select <= SETTLE_RESET;
            clockDivide        <= CLKDIV_RESET;
            moduleStandby      <= MODSTBY_RESET;
            prdata             <= 32'h0;
        end else begin
            standby_select     <= next_standby_select;
            settle_time_select <= next_settle_time_select;
            clockDivide        <= next_clockDivide;
            moduleStandby      <= next_moduleStandby;
            if (psel && !penable && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end

    // NMI or enabled, unmasked IRQ0-2 wake software standby
    assign wakeIrq = nmiReq || (|(irqReq & irqEnable) && !cpuIrqMasked);

    always_comb begin
        next_mode          = mode;
        next_settleCnt     = settleCnt;
        next_intExcStart   = 1'b0;
        next_resetExcStart = 1'b0;
        case (mode)
            RUN: begin
                if (!stbyLevel) begin
                    next_mode = HWSTBY;
                end else if (!resetLevel) begin
                    next_mode = RESET_HOLD;
                end else if (sleepExec) begin
                    next_mode = standby_select ? SWSTBY : SLEEP;
                end
            end
            SLEEP: begin
                if (!stbyLevel) begin
                    next_mode = HWSTBY;
                end else if (!resetLevel) begin
                    next_mode = RESET_HOLD;
                end else if (intAccepted) begin
                    // CPU accepts only enabled, unmasked sources or NMI
                    next_mode        = RUN;
                    next_intExcStart = 1'b1;
                end
            end
            SWSTBY: begin
                if (!stbyLevel) begin
                    next_mode = HWSTBY;
                end else if (!resetLevel) begin
                    next_mode = RESET_HOLD;
                end else if (wakeIrq) begin
                    next_mode      = SETTLE;
                    next_settleCnt = settle_states(settle_time_select);
                end
            end
            SETTLE: begin
                if (!stbyLevel) begin
                    next_mode = HWSTBY;
                end else if (!resetLevel) begin
                    next_mode = RESET_HOLD;
                end else if (divTick) begin
                    next_settleCnt = SETTLE_CNT_WIDTH'(settleCnt - 1'b1);
                    if (settleCnt == SETTLE_CNT_WIDTH'(1)) begin
                        next_mode        = RUN;
                        next_intExcStart = 1'b1;
                    end
                end
            end
            RESET_HOLD: begin
                if (!stbyLevel) begin
                    next_mode = HWSTBY;
                end else if (resetLevel) begin
                    next_mode          = RUN;
                    next_resetExcStart = 1'b1;
                end
            end
            HWSTBY: begin
                if (stbyLevel) begin
                    next_mode = RESET_HOLD;
                end
            end
            default: next_mode = RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode          <= RUN;
            settleCnt     <= '0;
            intExcStart   <= 1'b0;
            resetExcStart <= 1'b0;
        end else begin
            mode          <= next_mode;
            settleCnt     <= next_settleCnt;
            intExcStart   <= next_intExcStart;
            resetExcStart <= next_resetExcStart;
        end
    end

    always_comb begin
        cpuHalt     = (mode != RUN);
        clockStop   = (mode == SWSTBY || mode == SETTLE || mode == HWSTBY);
        periphReset = (mode == SWSTBY || mode == SETTLE || mode == HWSTBY
                       || mode == RESET_HOLD);
        moduleHalt  = periphReset ? 8'hff : moduleStandby;
        refreshInit = (mode == SWSTBY);
        chipReset   = (mode == RESET_HOLD || mode == HWSTBY);
        hwStandby   = (mode == HWSTBY);
    end

    // Cycles spent settling, held against code and divide
    always_comb begin
        next_settleCycles = (mode == SETTLE) ? (SETTLE_CNT_WIDTH+3)'(settleCycles + 1'b1) : '0;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            settleCycles <= '0;
        end else begin
            settleCycles <= next_settleCycles;
        end
    end

    // Entry and sleep mode
    chk_sleep_entry: assert property (@(posedge clk) disable iff (rst)
        mode == RUN && stbyLevel && resetLevel && sleepExec && !standby_select
        |=> mode == SLEEP) else $error("sleep not entered");
    chk_hw_standby_pin_entry: assert property (@(posedge clk) disable iff (rst)
        mode == RUN && stbyLevel && resetLevel && sleepExec && standby_select
        |=> mode == SWSTBY && clockStop) else $error("standby not entered");
    chk_cpu_halt: assert property (@(posedge clk) disable iff (rst)
        mode == SLEEP |-> cpuHalt && !periphReset) else $error("sleep halt wrong");
    chk_sleep_modules: assert property (@(posedge clk) disable iff (rst)
        mode == SLEEP |-> moduleHalt == moduleStandby) else $error("module halt");
    chk_sleep_running: assert property (@(posedge clk) disable iff (rst)
        mode == SLEEP |-> !clockStop && !refreshInit) else $error("sleep stopped clock");
    chk_sleep_wake: assert property (@(posedge clk) disable iff (rst)
        mode == SLEEP && stbyLevel && resetLevel && intAccepted
        |=> mode == RUN && intExcStart) else $error("sleep wake lost");
    chk_sleep_nowake: assert property (@(posedge clk) disable iff (rst)
        mode == SLEEP && stbyLevel && resetLevel && !intAccepted
        |=> mode == SLEEP) else $error("spurious sleep wake");
    chk_sleep_reset: assert property (@(posedge clk) disable iff (rst)
        mode == SLEEP && stbyLevel && !resetLevel |=> mode == RESET_HOLD)
        else $error("reset from sleep");
    chk_sleep_hwstby: assert property (@(posedge clk) disable iff (rst)
        mode == SLEEP && !stbyLevel |=> hwStandby) else $error("hw standby sleep");

    // Software standby and settling
    chk_hw_standby_pin_reset: assert property (@(posedge clk) disable iff (rst)
        mode == RUN && stbyLevel && resetLevel && sleepExec && standby_select
        |=> periphReset && refreshInit && moduleHalt == 8'hff) else $error("standby resets");
    chk_refresh_release: assert property (@(posedge clk) disable iff (rst)
        mode == SETTLE |-> !refreshInit && periphReset) else $error("refresh init held");
    chk_masked_irq: assert property (@(posedge clk) disable iff (rst)
        mode == SWSTBY && stbyLevel && resetLevel && !nmiReq && cpuIrqMasked
        |=> mode == SWSTBY) else $error("masked irq woke");
    chk_hw_standby_pin_irq_off: assert property (@(posedge clk) disable iff (rst)
        mode == SWSTBY && stbyLevel && resetLevel && !nmiReq && (irqReq & irqEnable) == 3'h0
        |=> mode == SWSTBY) else $error("disabled irq woke");
    chk_nmi_wake: assert property (@(posedge clk) disable iff (rst)
        mode == SWSTBY && stbyLevel && resetLevel && nmiReq
        |=> mode == SETTLE && clockStop && !intExcStart) else $error("nmi wake lost");
    chk_settle_load: assert property (@(posedge clk) disable iff (rst)
        mode == SWSTBY && stbyLevel && resetLevel && wakeIrq
        |=> mode == SETTLE && settleCnt == settle_states($past(settle_time_select)))
        else $error("settle load");
    chk_settle_short: assert property (@(posedge clk) disable iff (rst)
        $rose(mode == SETTLE) && settle_time_select == 3'h6 && clockDivide == 2'h0
        && stbyLevel && resetLevel ##1 (stbyLevel && resetLevel) [*8]
        |-> mode == SETTLE) else $error("settle ended early");
    chk_settle_count: assert property (@(posedge clk) disable iff (rst)
        mode == SETTLE && stbyLevel && resetLevel && !divTick
        |=> settleCnt == $past(settleCnt)) else $error("settle counted early");
    chk_settle_time: assert property (@(posedge clk) disable iff (rst)
        mode == SETTLE && stbyLevel && resetLevel && divTick
        && settleCnt == SETTLE_CNT_WIDTH'(1)
        |-> settleCycles + 1'b1 == ({3'h0, settle_states(settle_time_select)} << clockDivide))
        else $error("settle length");

    // Pins and reset
    chk_hw_standby_pin_pinreset: assert property (@(posedge clk) disable iff (rst)
        mode == SWSTBY && stbyLevel && !resetLevel |=> mode == RESET_HOLD && !clockStop)
        else $error("reset clocks");
    chk_hw_standby_pin_hw: assert property (@(posedge clk) disable iff (rst)
        mode == SWSTBY && !stbyLevel |=> mode == HWSTBY) else $error("hw standby");
    chk_reset_exit: assert property (@(posedge clk) disable iff (rst)
        mode == RESET_HOLD && stbyLevel && resetLevel
        |=> mode == RUN && resetExcStart && !chipReset) else $error("reset exit lost");
    chk_select_reset: assert property (@(posedge clk)
        rst |=> standby_select == 1'b0) else $error("select reset");

    // Main scenarios reached
    cov_sleep_wake: cover property (@(posedge clk) disable iff (rst)
        mode == SLEEP ##1 mode == RUN);
    cov_hw_standby_pin_settle: cover property (@(posedge clk) disable iff (rst)
        mode == SETTLE ##1 mode == RUN);
    cov_settle_divided: cover property (@(posedge clk) disable iff (rst)
        mode == SETTLE && clockDivide == 2'h3 ##1 mode == RUN);
    cov_reset_exit: cover property (@(posedge clk) disable iff (rst) resetExcStart);
    cov_hw_standby: cover property (@(posedge clk) disable iff (rst) mode == HWSTBY);
endmodule

// *** test/cpu_model.sv ***
// CPU-side partner: accepts a pending interrupt while halted in light sleep.
// Assumes pending and masked already reflect peripheral enables and priority.
`timescale 1ns/100ps
module cpu_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Device state
    input  wire logic       halted,
    input  wire logic       clockStop,
    // Interrupt view and response delay
    input  wire logic       pending,
    input  wire logic       masked,
    input  wire logic [3:0] lag,
    // Acceptance pulse
    output logic            accept
);
    logic [3:0] delayCount;
    logic [3:0] next_delayCount;
    logic       next_accept;

    always_comb begin
        next_delayCount = 4'h0;
        next_accept     = 1'b0;
        // Gated core clock or masked source never accepts
        if (halted && !clockStop && pending && !masked && !accept) begin
            next_delayCount = delayCount + 4'h1;
            next_accept     = (delayCount >= lag);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            delayCount <= 4'h0;
            accept     <= 1'b0;
        end else begin
            delayCount <= next_delayCount;
            accept     <= next_accept;
        end
    end
endmodule

// *** test/power_down_mode_control_test.sv ***
// Testbench for the power-down mode controller: APB, sleep, standby, settling.
// Assumes the package and the CPU partner model are compiled first.
`timescale 1ns/100ps
module power_down_mode_control_test;
    import pwr_pkg::*;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]  paddr, moduleHalt;
    logic [31:0] pwdata, prdata, rd, ms;
    logic        sleepExec, intAccepted, nmiReq, cpuIrqMasked, resetPin_n, standbyPin_n;
    logic [2:0]  irqReq, irqEnable;
    logic        cpuHalt, clockStop, periphReset, refreshInit, intExcStart;
    logic        resetExcStart, chipReset, hwStandby, intPending;
    logic [3:0]  lag;
    int          err_count, checked, cycles, n;
    int          codes [5] = '{6, 6, 6, 6, 0};
    int          divs  [5] = '{0, 1, 2, 3, 0};

    power_down_mode_control uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .sleepExec(sleepExec), .intAccepted(intAccepted),
        .nmiReq(nmiReq), .irqReq(irqReq), .irqEnable(irqEnable),
        .cpuIrqMasked(cpuIrqMasked), .external_reset_pin_n(resetPin_n),
        .hw_standby_pin_n(standbyPin_n), .cpuHalt(cpuHalt), .clockStop(clockStop),
        .periphReset(periphReset), .moduleHalt(moduleHalt), .refreshInit(refreshInit),
        .intExcStart(intExcStart), .resetExcStart(resetExcStart),
        .chipReset(chipReset), .hwStandby(hwStandby));
    cpu_model cpu (.clk(clk), .rst(rst), .halted(cpuHalt), .clockStop(clockStop),
        .pending(intPending), .masked(cpuIrqMasked), .lag(lag), .accept(intAccepted));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            conclude();
        end
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmpRange(input int got, input int lo, input int hi);
        checked++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic waitSig(ref logic s, input int lim);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (s !== 1'b1 && n < lim);
    endtask

    task automatic enterSleep;
        @(posedge clk);
        sleepExec <= 1'b1;
        @(posedge clk);
        sleepExec <= 1'b0;
        #1;
    endtask

    task automatic pinReset(input logic sw);
        enterSleep();
        resetPin_n <= 1'b0;
        waitSig(chipReset, 10);
        cmp(chipReset, 1'b1);
        cmp(clockStop, 1'b0);
        // Held low long enough for settling
        repeat (20) @(posedge clk);
        resetPin_n <= 1'b1;
        waitSig(resetExcStart, 10);
        cmp(resetExcStart, 1'b1);
        $display("pin reset test done, standby %0d", sw);
    endtask

    task automatic pinStandby(input logic sw);
        enterSleep();
        standbyPin_n <= 1'b0;
        waitSig(hwStandby, 10);
        cmp(hwStandby, 1'b1);
        @(posedge clk);
        resetPin_n   <= 1'b0;
        repeat (10) @(posedge clk);
        standbyPin_n <= 1'b1;
        repeat (20) @(posedge clk);
        resetPin_n   <= 1'b1;
        waitSig(resetExcStart, 20);
        cmp(resetExcStart, 1'b1);
        $display("pin standby test done, standby %0d", sw);
    endtask

    function automatic int expStates(input int code, input int div);
        int base [8] = '{8192, 16384, 32768, 65536, 131072, 262144, 1024, 1024};
        return base[code] << div;
    endfunction

    task conclude;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata, sleepExec, nmiReq} = '0;
        {irqReq, irqEnable, cpuIrqMasked, intPending, lag} = '0;
        {err_count, checked, cycles} = '0;
        rst = 1'b1;
        resetPin_n = 1'b1;
        standbyPin_n = 1'b1;
        n = $urandom(4);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, SYSCTRL_OFFSET, '0);
        cmp(rd, 32'h0);
        apb(1'b0, STATUS_OFFSET, '0);
        cmp(rd, 32'(RUN));
        apb(1'b1, 8'h10, 32'hffff_ffff);
        cmp(er, 1'b1);
        apb(1'b0, 8'h10, '0);
        cmp(er, 1'b1);
        cmp(rd, 32'h0);
        $display("reset and map test done");
        ms = $urandom & 32'hff;
        apb(1'b1, MODSTBY_OFFSET, ms);
        enterSleep();
        cmp({cpuHalt, clockStop, periphReset}, 3'b100);
        cmp(moduleHalt, ms);
        apb(1'b0, STATUS_OFFSET, '0);
        cmp(rd, 32'(SLEEP));
        lag <= 4'($urandom % 6);
        intPending   <= 1'b1;
        cpuIrqMasked <= 1'b1;
        repeat (20) @(posedge clk);
        cmp(cpuHalt, 1'b1);
        cpuIrqMasked <= 1'b0;
        waitSig(intExcStart, 20);
        cmp(intExcStart, 1'b1);
        intPending <= 1'b0;
        @(posedge clk);
        #1;
        cmp({cpuHalt, intExcStart}, 2'b00);
        $display("sleep interrupt test done");
        pinReset(1'b0);
        pinStandby(1'b0);
        // Clock divide written before standby select and settle code, both read back
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, CLKDIV_OFFSET, 32'(divs[i]));
            apb(1'b1, SYSCTRL_OFFSET, (32'h1 << HW_STANDBY_PIN_SEL_BIT) | (codes[i] << SETTLE_LSB));
            apb(1'b0, SYSCTRL_OFFSET, '0);
            cmp(rd, (32'h1 << HW_STANDBY_PIN_SEL_BIT) | (codes[i] << SETTLE_LSB));
            apb(1'b0, CLKDIV_OFFSET, '0);
            cmp(rd, 32'(divs[i]));
            enterSleep();
            cmp({clockStop, periphReset, refreshInit, cpuHalt}, 4'hf);
            irqReq    <= 3'h7;
            irqEnable <= 3'h0;
            repeat (10) @(posedge clk);
            irqEnable    <= 3'h7;
            cpuIrqMasked <= 1'b1;
            repeat (10) @(posedge clk);
            #1;
            cmp(clockStop, 1'b1);
            @(posedge clk);
            cpuIrqMasked <= 1'b0;
            irqEnable    <= 3'h1 << ($urandom % 3);
            nmiReq       <= (i == 4);
            irqReq       <= (i == 4) ? 3'h0 : 3'h7;
            waitSig(intExcStart, 300000);
            cmpRange(n, expStates(codes[i], divs[i]), expStates(codes[i], divs[i]) + 4);
            cmp(intExcStart, 1'b1);
            {nmiReq, irqReq, irqEnable} <= '0;
            $display("settle test done, code %0d div %0d", codes[i], divs[i]);
        end
        pinReset(1'b1);
        pinStandby(1'b1);
        // Mid-run reset while standby select is set
        @(posedge clk);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        cmp({cpuHalt, moduleHalt}, 9'h0);
        apb(1'b0, SYSCTRL_OFFSET, '0);
        cmp(rd, 32'h0);
        enterSleep();
        cmp({cpuHalt, clockStop, periphReset}, 3'b100);
        $display("mid-run reset test done");
        conclude();
    end
endmodule
